// ---- verilog/tws_top.sv ----
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "tws_params.svh"
// Overview of operation
// - Match address against four programmable registers.
// - Ignore line pulses shorter than 50 ns.
// - Repeated start detected only after receiving.
// - Master-select bit picks software master mode.
// - Data drive enable drives data output level.
// - Master mode drives clock from clock bit.
// - Data input latched on clock rising edge.
// - Reset comes up idle in slave mode.
// - Enabled when peripheral enable clear or remap.
// - Flag set after valid start and address.
// - Interrupt needs flag, enable, global enable.
// - Data register access clears flag, interrupt.
// - Second access per event halts until reset.
// - Byte event vectors to fixed address 003BH.
// - First byte shows address and direction bit.
// - Direction flag selects transmit or receive.
// - Clock held low until flag cleared.
// - Flag only for acknowledged bytes.
// - Events continue until stop, not-acknowledge, halt or reset.
// - Stop or not-acknowledge returns to idle.
// - Soft reset forces idle state.
// - Interface held in reset while bit set.
// - Device sets direction flag itself.

module tws_top #(
  parameter int AW = 10,
  parameter int FILT = `TWS_FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic irq_o,
  output logic [15:0] irq_vector_o
);

  // Refuse settings that the address decode or filter cannot serve.
  if (AW < 10 || FILT < 1 || FILT > 15) begin : g_chk
    $error("tws_top: unsupported AW or FILT");
  end

  // Registered state and its next value.
  tws_pkg::tws_state_t q;
  tws_pkg::tws_state_t n;

  // Bus decode helpers.
  logic req;
  logic [7:0] idx;
  logic mapped;
  logic wr;
  logic dacc;
  // Line events seen on the filtered signals.
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic active;

  // Builds the state after reset: slave mode, idle, lines released.
  function automatic tws_pkg::tws_state_t rst_val();
    tws_pkg::tws_state_t r;
    r = '0;
    r.st = tws_pkg::ST_IDLE;
    r.sda_s1 = 1'b1;
    r.sda_s2 = 1'b1;
    r.scl_s1 = 1'b1;
    r.scl_s2 = 1'b1;
    r.sda_f = 1'b1;
    r.scl_f = 1'b1;
    r.dbuf = `TWS_RST_DATA;
    r.addr[0] = `TWS_RST_ADDR0;
    r.addr[1] = `TWS_RST_ADDRN;
    r.addr[2] = `TWS_RST_ADDRN;
    r.addr[3] = `TWS_RST_ADDRN;
    r.cout = 1'b1;
    r.dout = 1'b1;
    r.sda_o = 1'b1;
    r.scl_o = 1'b1;
    return r;
  endfunction

  localparam tws_pkg::tws_state_t RST = rst_val();

  // Spike filter: a new level is taken only once it has stood for
  // FILT samples; returns the level above the count.
  function automatic logic [4:0] filt(input logic lvl,
                                      input logic [3:0] cnt,
                                      input logic raw);
    logic [3:0] c;
    c = cnt + 4'h1;
    if (raw == lvl)
    begin
      filt = {lvl, 4'h0};
    end
    else if (c >= 4'(FILT))
    begin
      filt = {raw, 4'h0};
    end
    else
    begin
      filt = {lvl, c};
    end
  endfunction

  // True when the 7-bit address in the byte matches any register.
  function automatic logic hit_any(input logic [7:0] b,
                                   input logic [3:0][7:0] a);
    hit_any = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (b[7:1] == a[i][6:0])
      begin
        hit_any = 1'b1;
      end
    end
  endfunction

  // All next-state logic of the block.
  always_comb
  begin
    n = q;
    // Pins pass two flip-flops before anything reads them.
    n.sda_s1 = sda_i;
    n.sda_s2 = q.sda_s1;
    n.scl_s1 = scl_i;
    n.scl_s2 = q.scl_s1;
    {n.sda_f, n.sda_fc} = filt(q.sda_f, q.sda_fc, q.sda_s2);
    {n.scl_f, n.scl_fc} = filt(q.scl_f, q.scl_fc, q.scl_s2);
    scl_rise = ~q.scl_f & n.scl_f;
    scl_fall = q.scl_f & ~n.scl_f;
    start = q.scl_f & n.scl_f & q.sda_f & ~n.sda_f;
    stop = q.scl_f & n.scl_f & ~q.sda_f & n.sda_f;

    // A classic cycle is answered with a one-cycle acknowledge.
    req = cyc_i & stb_i & ~q.ack;
    n.ack = req;
    idx = adr_i[9:2];
    mapped = ((adr_i >> 10) == '0) && (adr_i[1:0] == 2'b00);
    wr = req & we_i & sel_i[0] & mapped;
    dacc = req & mapped & (idx == `TWS_IDX_DATA);

    // Read data is latched with the acknowledge; unmapped reads zero.
    n.rdat = 8'h00;
    if (req && mapped)
    begin
      unique case (idx)
        `TWS_IDX_ADDR0: n.rdat = q.addr[0];
        `TWS_IDX_ADDR1: n.rdat = q.addr[1];
        `TWS_IDX_ADDR2: n.rdat = q.addr[2];
        `TWS_IDX_ADDR3: n.rdat = q.addr[3];
        `TWS_IDX_DATA: n.rdat = q.dbuf;
        `TWS_IDX_CTRL:
        begin
          n.rdat[`TWS_B_DOUT] = q.dout;
          n.rdat[`TWS_B_DDRV] = q.ddrv;
          n.rdat[`TWS_B_COUT] = q.cout;
          n.rdat[`TWS_B_DIN] = q.din;
          n.rdat[`TWS_B_MSTR] = q.mstr;
          n.rdat[`TWS_B_SRST] = q.srst;
          n.rdat[`TWS_B_DIR] = q.dir;
          n.rdat[`TWS_B_FLAG] = q.flag;
        end
        `TWS_IDX_ENAB:
        begin
          n.rdat[`TWS_B_PEN] = q.pen;
          n.rdat[`TWS_B_REMAP] = q.remap;
          n.rdat[`TWS_B_IEN] = q.ien;
          n.rdat[`TWS_B_GIE] = q.gie;
          n.rdat[`TWS_B_HALT] = q.halt;
        end
        default: n.rdat = 8'h00;
      endcase
    end

    // Register writes; status bits are not writable.
    if (wr)
    begin
      unique case (idx)
        `TWS_IDX_ADDR0: n.addr[0] = dat_i[7:0];
        `TWS_IDX_ADDR1: n.addr[1] = dat_i[7:0];
        `TWS_IDX_ADDR2: n.addr[2] = dat_i[7:0];
        `TWS_IDX_ADDR3: n.addr[3] = dat_i[7:0];
        `TWS_IDX_DATA: n.dbuf = dat_i[7:0];
        `TWS_IDX_CTRL:
        begin
          n.dout = dat_i[`TWS_B_DOUT];
          n.ddrv = dat_i[`TWS_B_DDRV];
          n.cout = dat_i[`TWS_B_COUT];
          n.mstr = dat_i[`TWS_B_MSTR];
          n.srst = dat_i[`TWS_B_SRST];
        end
        `TWS_IDX_ENAB:
        begin
          n.pen = dat_i[`TWS_B_PEN];
          n.remap = dat_i[`TWS_B_REMAP];
          n.ien = dat_i[`TWS_B_IEN];
          n.gie = dat_i[`TWS_B_GIE];
        end
        default: n.acc = q.acc;
      endcase
    end

    // Any data register access clears the flag; a second access
    // before the next event stops the controller.
    if (dacc)
    begin
      n.flag = 1'b0;
      if (q.acc)
      begin
        n.halt = 1'b1;
      end
      n.acc = 1'b1;
    end

    if (scl_rise)
    begin
      n.din = n.sda_f;
    end

    // The slave runs only when enabled, in slave mode, not halted
    // and out of soft reset.
    // enable condition
    active = (~q.pen | q.remap) & ~q.mstr & ~q.halt & ~q.srst;

    if (q.srst)
    begin
      n.halt = 1'b0;
      n.flag = 1'b0;
      n.acc = 1'b0;
      n.dir = 1'b0;
    end

    // Slave state machine.
    if (!active)
    begin
      n.st = tws_pkg::ST_IDLE;
      n.sdl = 1'b0;
    end
    else if (stop)
    begin
      n.st = tws_pkg::ST_IDLE;
      n.sdl = 1'b0;
    end
    else if (start && (q.st == tws_pkg::ST_IDLE || !q.dir))
    begin
      n.st = tws_pkg::ST_ADDR;
      n.bits = 4'h0;
      n.sdl = 1'b0;
    end
    else
    begin
      unique case (q.st)
        tws_pkg::ST_IDLE:
        begin
          n.sdl = 1'b0;
        end
        tws_pkg::ST_ADDR:
        begin
          // Address and direction bit shift in MSB first.
          if (scl_rise)
          begin
            n.shift = {q.shift[6:0], n.sda_f};
            n.bits = q.bits + 4'h1;
          end
          else if (scl_fall && q.bits == 4'h8)
          begin
            if (hit_any(q.shift, q.addr))
            begin
              n.sdl = 1'b1;
              n.st = tws_pkg::ST_AACK;
              n.dir = q.shift[0];
              n.dbuf = q.shift;
            end
            else
            begin
              n.st = tws_pkg::ST_IDLE;
            end
          end
        end
        tws_pkg::ST_AACK, tws_pkg::ST_RACK:
        begin
          // The acknowledge ends at the falling clock edge.
          if (scl_fall)
          begin
            n.sdl = 1'b0;
            n.flag = 1'b1;
            n.acc = 1'b0;
            n.st = tws_pkg::ST_WAIT;
          end
        end
        tws_pkg::ST_RX:
        begin
          // Received data shifts in MSB first.
          if (scl_rise)
          begin
            n.shift = {q.shift[6:0], n.sda_f};
            n.bits = q.bits + 4'h1;
          end
          else if (scl_fall && q.bits == 4'h8)
          begin
            n.sdl = 1'b1;
            n.dbuf = q.shift;
            n.st = tws_pkg::ST_RACK;
          end
        end
        tws_pkg::ST_TX:
        begin
          // Each bit is set up after a falling edge.
          if (scl_rise)
          begin
            n.bits = q.bits + 4'h1;
          end
          else if (scl_fall)
          begin
            if (q.bits == 4'h8)
            begin
              n.sdl = 1'b0;
              n.st = tws_pkg::ST_TACK;
            end
            else
            begin
              n.sdl = ~q.shift[6];
              n.shift = {q.shift[6:0], 1'b0};
            end
          end
        end
        tws_pkg::ST_TACK:
        begin
          // The master's answer is sampled at the rising edge.
          if (scl_rise)
          begin
            n.nak = n.sda_f;
          end
          else if (scl_fall)
          begin
            if (q.nak)
            begin
              n.st = tws_pkg::ST_IDLE;
            end
            else
            begin
              n.flag = 1'b1;
              n.acc = 1'b0;
              n.st = tws_pkg::ST_WAIT;
            end
          end
        end
        tws_pkg::ST_WAIT:
        begin
          if (!q.flag)
          begin
            n.bits = 4'h0;
            if (q.dir)
            begin
              n.shift = q.dbuf;
              n.sdl = ~q.dbuf[7];
              n.st = tws_pkg::ST_TX;
            end
            else
            begin
              n.st = tws_pkg::ST_RX;
            end
          end
        end
      endcase
    end

    // Pin drivers.
    if (q.mstr)
    begin
      n.sda_oe = q.ddrv;
      n.sda_o = q.dout;
      n.scl_oe = 1'b1;
      n.scl_o = q.cout;
    end
    else
    begin
      // The slave only ever pulls the lines low.
      n.sda_oe = n.sdl;
      n.sda_o = 1'b0;
      n.scl_oe = (n.st == tws_pkg::ST_WAIT);
      n.scl_o = 1'b0;
    end

    n.irq = n.flag & q.ien & q.gie;
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q <= RST;
    end
    else if (ce_i)
    begin
      q <= n;
    end
  end

  // Outputs come straight from the state register, except the fixed interrupt vector.
  assign dat_o = {24'h000000, q.rdat};
  assign ack_o = q.ack;
  assign sda_o = q.sda_o;
  assign sda_oe_o = q.sda_oe;
  assign scl_o = q.scl_o;
  assign scl_oe_o = q.scl_oe;
  assign irq_o = q.irq;
  assign irq_vector_o = `TWS_VECTOR;

endmodule // tws_top

// ---- verilog/tws_params.svh ----
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
// Register indexes; the bus byte address is four times the index.
`define TWS_IDX_ADDR0 8'h9b
`define TWS_IDX_ADDR1 8'h91
`define TWS_IDX_ADDR2 8'h92
`define TWS_IDX_ADDR3 8'h93
`define TWS_IDX_DATA 8'h9a
`define TWS_IDX_CTRL 8'he8
`define TWS_IDX_ENAB 8'he9
// Reset values.
`define TWS_RST_ADDR0 8'h55
`define TWS_RST_ADDRN 8'h7f
`define TWS_RST_DATA 8'h00
// Bit positions in the two-wire control register.
`define TWS_B_DOUT 7
`define TWS_B_DDRV 6
`define TWS_B_COUT 5
`define TWS_B_DIN 4
`define TWS_B_MSTR 3
`define TWS_B_SRST 2
`define TWS_B_DIR 1
`define TWS_B_FLAG 0
// Bit positions in the enable register.
`define TWS_B_PEN 0
`define TWS_B_REMAP 1
`define TWS_B_IEN 2
`define TWS_B_GIE 3
`define TWS_B_HALT 4
// Fixed interrupt vector of the byte-complete event.
`define TWS_VECTOR 16'h003b
// Spike filter: shortest pulse kept, and the clock period.
`define TWS_SPIKE_NS 50
`define TWS_CLK_NS 40
`define TWS_FILT_CYC ((`TWS_SPIKE_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`endif

// ---- verilog/tws_pkg.sv ----
package tws_pkg;

  // Slave controller states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_RX = 3'b011,
    ST_RACK = 3'b100,
    ST_TX = 3'b101,
    ST_TACK = 3'b110,
    ST_WAIT = 3'b111
  } tws_fsm_t;

  // Complete state of the block.
  typedef struct packed {
    tws_fsm_t st;
    logic sda_s1;
    logic sda_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_f;
    logic scl_f;
    logic [3:0] sda_fc;
    logic [3:0] scl_fc;
    logic [7:0] shift;
    logic [3:0] bits;
    logic nak;
    logic sdl;
    logic [7:0] dbuf;
    logic [3:0][7:0] addr;
    logic mstr;
    logic ddrv;
    logic dout;
    logic cout;
    logic din;
    logic srst;
    logic pen;
    logic remap;
    logic ien;
    logic gie;
    logic flag;
    logic dir;
    logic acc;
    logic halt;
    logic sda_o;
    logic sda_oe;
    logic scl_o;
    logic scl_oe;
    logic irq;
    logic ack;
    logic [7:0] rdat;
  } tws_state_t;

endpackage

// ---- verification/tws_checker.sv ----
`timescale 1ns/1ps
// Port-level checks of the two-wire block.
module tws_checker #(
  parameter int AW = 10,
  parameter int FILT = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic irq_o,
  input wire logic [15:0] irq_vector_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Control write and data access, both seen while ack is high.
  logic wr_ctl;
  logic dat_acc;
  assign wr_ctl = ack_o && cyc_i && stb_i && we_i && sel_i[0]
    && adr_i[9:2] == 8'he8;
  assign dat_acc = ack_o && cyc_i && stb_i && adr_i[9:2] == 8'h9a;
  property p_rst;
    $rose(rst_n_i) |-> !ack_o && !sda_oe_o && !scl_oe_o && !irq_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
  property p_take;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_take: assert property (p_take)
    else $error("bus request not answered next cycle");
  property p_one;
    ack_o |=> !ack_o;
  endproperty
  a_one: assert property (p_one)
    else $error("ack longer than one cycle");
  property p_hi;
    ack_o |-> dat_o[31:8] == 24'h000000;
  endproperty
  a_hi: assert property (p_hi)
    else $error("upper read data not zero");
  property p_vec;
    irq_vector_o == 16'h003b;
  endproperty
  a_vec: assert property (p_vec)
    else $error("wrong interrupt vector");
  property p_irq_clr;
    dat_acc |=> !irq_o;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("interrupt kept after data access");
  property p_rel;
    dat_acc |-> ##[1:3] !scl_oe_o;
  endproperty
  a_rel: assert property (p_rel)
    else $error("clock still held after data access");
  property p_mclk;
    wr_ctl && dat_i[3] && !dat_i[2] |->
      ##3 scl_oe_o && scl_o == $past(dat_i[5], 3);
  endproperty
  a_mclk: assert property (p_mclk)
    else $error("master clock pin wrong");
  property p_msda;
    wr_ctl && dat_i[3] && !dat_i[2] |-> ##3 sda_oe_o == $past(dat_i[6], 3)
      && (!sda_oe_o || sda_o == $past(dat_i[7], 3));
  endproperty
  a_msda: assert property (p_msda)
    else $error("master data pin wrong");
  property p_srst;
    wr_ctl && dat_i[2] && !dat_i[3] |-> ##3 (!sda_oe_o && !scl_oe_o)[*3];
  endproperty
  a_srst: assert property (p_srst)
    else $error("lines driven during soft reset");
  c_stretch: cover property ($rose(scl_oe_o));
  c_irq: cover property ($rose(irq_o));
  c_data: cover property (dat_acc);
endmodule // tws_checker

bind tws_top tws_checker #(.AW(AW), .FILT(FILT)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .irq_o(irq_o),
  .irq_vector_o(irq_vector_o)
);

// ---- verification/tws_master_model.sv ----
`timescale 1ns/1ps
// Far-side bus master; a 320 ns bit, pulling lines low only.
module tws_master_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_lo_o,
  output logic sda_lo_o
);
  initial scl_lo_o = 1'b0;
  initial sda_lo_o = 1'b0;
  task automatic bit_x(input logic b, output logic r);
    int n;
    begin
      // Data changes a little after the clock fall, and the low phase
      // is long enough for the slave's pin-to-drive latency.
      #20;
      sda_lo_o = !b;
      #180;
      scl_lo_o = 1'b0;
      n = 0;
      // Waits, within a bound, while the slave stretches the clock.
      while (scl_i !== 1'b1 && n < 400)
      begin
        #40;
        n++;
      end
      // A stretch that never ends is counted as a mismatch.
      if (n >= 400)
        testbench.err_count++;
      #60;
      r = sda_i;
      #60;
      scl_lo_o = 1'b1;
    end
  endtask
  task automatic start();
    begin
      #10;
      sda_lo_o = 1'b0;
      #160;
      scl_lo_o = 1'b0;
      #160;
      sda_lo_o = 1'b1;
      #160;
      scl_lo_o = 1'b1;
    end
  endtask
  task automatic stop();
    begin
      #10;
      sda_lo_o = 1'b1;
      #160;
      scl_lo_o = 1'b0;
      #160;
      sda_lo_o = 1'b0;
      #160;
    end
  endtask
  task automatic send(input logic [7:0] d, output logic a);
    logic r;
    begin
      #10;
      for (int i = 7; i >= 0; i--)
        bit_x(d[i], r);
      bit_x(1'b1, r);
      a = !r;
      #320;
    end
  endtask
  task automatic recv(input logic nak, output logic [7:0] d);
    logic r;
    begin
      #10;
      for (int i = 7; i >= 0; i--)
      begin
        bit_x(1'b1, r);
        d[i] = r;
      end
      bit_x(nak, r);
      #320;
    end
  endtask
endmodule // tws_master_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
// Self-checking bench of the two-wire block.
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack, sda_o, sda_oe, scl_o, scl_oe, irq, scl_lo, sda_lo, a;
  logic [15:0] vec;
  logic sda_pd = 1'b0;
  logic scl_gl = 1'b0;
  logic sda_w;
  logic scl_w;
  logic [7:0] q;
  int err_count = 0;
  int checked = 0;
  int cyc_cnt = 0;
  // Rows of {write, index, data or expected read}.
  logic [16:0] rows [0:16] = '{17'h09b55, 17'h0917f, 17'h0927f,
    17'h0937f, 17'h09a00, 17'h0e8a0, 17'h0e900, 17'h19112, 17'h09112,
    17'h1932a, 17'h0932a, 17'h11033, 17'h01000, 17'h1e8b3, 17'h0e8a0,
    17'h1e910, 17'h0e900};
  // Wired-and lines with pull-ups; the glitch source only raises.
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_lo & ~sda_pd;
  assign scl_w = ((scl_oe ? scl_o : 1'b1) & ~scl_lo) | scl_gl;
  always #20 clk = ~clk;
  tws_top #(.AW(10), .FILT(2)) dut_u (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .irq_o(irq),
    .irq_vector_o(vec)
  );
  tws_master_model m_u (.scl_i(scl_w), .sda_i(sda_w),
    .scl_lo_o(scl_lo), .sda_lo_o(sda_lo));
  // Counts mismatches.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      checked++;
      if (got !== exp)
      begin
        err_count++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One classic bus cycle, held until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] ix,
    input logic [7:0] d, output logic [7:0] r);
    int n;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      wdat <= {24'h000000, d};
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        n++;
      end
      // A bus cycle that is never answered counts as a mismatch.
      if (ack !== 1'b1)
        err_count++;
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  // Reads a register and compares the masked bits.
  task automatic rd(input logic [7:0] ix, input logic [7:0] m,
    input logic [7:0] e);
    logic [7:0] v;
    begin
      wb(1'b0, ix, 8'h00, v);
      chk({8'h00, v & m}, {8'h00, e});
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    begin
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Cuts a hang short.
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      err_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      wb(rows[i][16], rows[i][15:8], rows[i][7:0], q);
      if (!rows[i][16])
        chk({8'h00, q}, {8'h00, rows[i][7:0]});
    end
    wb(1'b1, 8'he8, 8'ha4, q);
    wb(1'b1, 8'he8, 8'ha0, q);
    $display("test registers done");
    m_u.start();
    m_u.send(8'h54, a);
    chk({15'h0000, a}, 16'h0001);
    chk({15'h0000, scl_oe}, 16'h0001);
    rd(8'he8, 8'h03, 8'h01);
    rd(8'h9a, 8'hff, 8'h54);
    m_u.send(8'hc3, a);
    rd(8'he8, 8'h03, 8'h01);
    rd(8'h9a, 8'hff, 8'hc3);
    $display("test receive done");
    wb(1'b1, 8'he9, 8'h0c, q);
    m_u.start();
    m_u.send(8'h25, a);
    chk({15'h0000, a}, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    chk(vec, 16'h003b);
    rd(8'he8, 8'h03, 8'h03);
    wb(1'b1, 8'h9a, 8'ha5, q);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    m_u.recv(1'b1, q);
    chk({8'h00, q}, 16'h00a5);
    rd(8'he8, 8'h01, 8'h00);
    m_u.stop();
    m_u.start();
    m_u.send(8'h66, a);
    chk({15'h0000, a}, 16'h0000);
    m_u.stop();
    rd(8'he8, 8'h01, 8'h00);
    $display("test transmit done");
    wb(1'b1, 8'he9, 8'h01, q);
    m_u.start();
    m_u.send(8'h54, a);
    chk({15'h0000, a}, 16'h0000);
    m_u.stop();
    wb(1'b1, 8'he9, 8'h03, q);
    m_u.start();
    m_u.send(8'h54, a);
    chk({15'h0000, a}, 16'h0001);
    rd(8'h9a, 8'hff, 8'h54);
    rd(8'h9a, 8'h00, 8'h00);
    rd(8'he9, 8'h10, 8'h10);
    chk({15'h0000, scl_oe}, 16'h0000);
    wb(1'b1, 8'he8, 8'ha4, q);
    rd(8'he9, 8'h10, 8'h00);
    rd(8'he8, 8'h03, 8'h00);
    wb(1'b1, 8'he8, 8'ha0, q);
    m_u.stop();
    $display("test halt done");
    wb(1'b1, 8'he8, 8'h48, q);
    repeat (3) @(posedge clk);
    chk({12'h000, sda_oe, sda_o, scl_oe, scl_o}, 16'h000a);
    wb(1'b1, 8'he8, 8'ha8, q);
    repeat (3) @(posedge clk);
    chk({13'h0000, sda_oe, scl_oe, scl_o}, 16'h0003);
    rd(8'he8, 8'h10, 8'h10);
    wb(1'b1, 8'he8, 8'h88, q);
    sda_pd <= 1'b1;
    wb(1'b1, 8'he8, 8'ha8, q);
    // Lets the clock rise pass the synchroniser and the filter.
    repeat (4) @(posedge clk);
    rd(8'he8, 8'h10, 8'h00);
    wb(1'b1, 8'he8, 8'h88, q);
    sda_pd <= 1'b0;
    #30;
    scl_gl <= 1'b1;
    #20;
    scl_gl <= 1'b0;
    rd(8'he8, 8'h10, 8'h00);
    wb(1'b1, 8'he8, 8'ha0, q);
    $display("test master done");
    summarize();
  end
endmodule // testbench
